// File: rtl/tlmc_pkg.sv
package tlmc_pkg;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [7:0] OFS_AUX_A_HI = 8'h6A;
	localparam logic [7:0] OFS_AUX_A_LO = 8'h6B;
	localparam logic [7:0] OFS_AUX_B_HI = 8'h6C;
	localparam logic [7:0] OFS_AUX_B_LO = 8'h6D;
	localparam logic [7:0] OFS_RANGE    = 8'h86;
	localparam logic [7:0] OFS_SRC_CFG  = 8'h8B;
	localparam logic [7:0] OFS_INDEX    = 8'hB0;
	localparam logic [7:0] OFS_VALUE    = 8'hB1;
	localparam logic [7:0] OFS_MODE     = 8'hB2;
	localparam logic [7:0] OFS_SUPPLY   = 8'hDC;

	// ************************************************
	// field positions
	// ************************************************
	localparam int BIT_AUX_A_EN    = 0;
	localparam int BIT_AUX_B_EN    = 1;
	localparam int BIT_SUPPLY_EN   = 2;
	localparam int BIT_EXT_TEMP    = 3;
	localparam int BIT_AUTO_EN     = 0;
	localparam int BIT_TABLE_EN    = 1;
	localparam int BIT_SUPPLY_SEL  = 0;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [2:0] RST_RANGE   = 3'h0;
	localparam logic [7:0] RST_SRC_CFG = 8'h07;
	localparam logic [7:0] RST_MODE    = 8'h03;
	localparam logic [7:0] RST_SUPPLY  = 8'h00;
	localparam logic [7:0] RST_INDEX   = 8'h80;
	localparam logic [7:0] RST_VALUE   = 8'h00;

	// ************************************************
	// lookup table and result format
	// ************************************************
	localparam logic [7:0]  LUT_BASE     = 8'h80;
	localparam logic [6:0]  LUT_LAST_IDX = 7'h47;
	localparam logic [9:0]  LUT_SPAN_DEG = 10'h08E;
	localparam logic [9:0]  LUT_LOW_DEG  = 10'h028;
	localparam logic [15:0] RES_MASK     = 16'hFFF8;
	localparam logic [15:0] TEMP_MIN_EXT = 16'hD800;
	localparam logic [15:0] TEMP_MAX_EXT = 16'h67F0;
	localparam logic [15:0] TEMP_MIN_INT = 16'h8800;
	localparam logic [15:0] TEMP_MAX_INT = 16'h7FF8;
	localparam logic [4:0]  AVG_LAST_TEMP  = 5'h0F;
	localparam logic [4:0]  AVG_LAST_OTHER = 5'h07;

	// ************************************************
	// channels and full-scale currents
	// ************************************************
	localparam logic [2:0] CH_TEMP   = 3'h0;
	localparam logic [2:0] CH_SUPPLY = 3'h1;
	localparam logic [2:0] CH_BIAS   = 3'h2;
	localparam logic [2:0] CH_DIODE  = 3'h3;
	localparam logic [2:0] CH_RXPWR  = 3'h4;
	localparam logic [2:0] CH_AUX_A  = 3'h5;
	localparam logic [2:0] CH_AUX_B  = 3'h6;
	localparam logic [10:0] FS_UA_0 = 11'h04B;
	localparam logic [10:0] FS_UA_1 = 11'h096;
	localparam logic [10:0] FS_UA_2 = 11'h12C;
	localparam logic [10:0] FS_UA_3 = 11'h258;
	localparam logic [10:0] FS_UA_4 = 11'h4B0;

	typedef enum logic [2:0] {
		SEQ_START = 3'b001,
		SEQ_WAIT  = 3'b010,
		SEQ_AVG   = 3'b100
	} tlmc_seq_e;

endpackage

// File: rtl/tlmc_avg.sv
module tlmc_avg import tlmc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        smp_valid,
	input  wire logic [15:0] smp_data,
	input  wire logic        smp_temp,
	output logic             avg_done,
	output logic      [15:0] avg_result
);

	typedef struct packed {
		logic [4:0]  cnt;
		logic [19:0] sum;
		logic [15:0] res;
		logic        done;
	} tlmc_avg_s;

	tlmc_avg_s s_ff;
	tlmc_avg_s nxt_s;
	logic [19:0] ext;
	logic [19:0] tot;

	// ************************************************
	// accumulate 16 temperature or 8 other samples
	// ************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		ext = smp_temp ? {{4{smp_data[15]}}, smp_data}
			: {4'h0, smp_data};
		tot = s_ff.sum + ext;
		if (smp_valid) begin
			if (s_ff.cnt == (smp_temp ? AVG_LAST_TEMP
					: AVG_LAST_OTHER)) begin
				nxt_s.res  = smp_temp ? tot[19:4]
					: tot[18:3];
				nxt_s.done = 1'b1;
				nxt_s.sum  = 20'h00000;
				nxt_s.cnt  = 5'h00;
			end else begin
				nxt_s.sum = tot;
				nxt_s.cnt = s_ff.cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign avg_done   = s_ff.done;
	assign avg_result = s_ff.res;

endmodule // tlmc_avg

// File: rtl/tlmc_top.sv
// Summary of operation
// - range code 000..100 selects 75, 150, 300, 600 or 1200 uA full scale.
// - output code is 8 bits; FFh means full scale in every range.
// - automatic lookup indexes stored 8-bit entries, one per 2 degrees.
// - -40 C maps to 80h up to C7h at +102 C, clamped both ends.
// - external select makes aux B result index the table instead.
// - internal temperature keeps converting and alone feeds temperature flags.
// - internal temperature clamps tighter when external select is set.
// - aux B result carries its own update for its own flag.
// - table enable and auto enable both reset to one.
// - both bits zero: host writes value, pointer and copy stop.
// - table off, auto on: pointer tracks temperature, host writes value.
// - table on, auto off: host writes pointer, value follows that entry.
// - both on: device sets pointer, copies entry, drives new code.
// - seven channels polled round robin, each refreshed once per frame.
// - results are 16-bit words with 13-bit resolution.
// - eight conversions averaged, internal temperature sixteen.
// - aux A, aux B and supply channels may be left out.
// - aux results readable at 6Ah to 6Dh as raw words.
// - supply select one measures 1.8 V rail, zero the 3.3/5 V rail.
// - supply enable zero removes the supply channel whatever the select.
// - power-on flag follows its own input, not the supply channel.
// - laser temperature on aux uses the module temperature format.
// - high byte whole signed degrees, low byte 1/256 degree.
module tlmc_top import tlmc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_lut_sel,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             adc_start,
	output logic      [2:0]  adc_chan,
	output logic             adc_supply_sel,
	input  wire logic        adc_done,
	input  wire logic [15:0] adc_data,
	output logic             chan_result_vld,
	output logic      [2:0]  chan_result_id,
	output logic      [15:0] chan_result,
	output logic             int_temp_upd,
	output logic      [15:0] int_temp_result,
	output logic             aux_b_upd,
	output logic      [7:0]  mod_current_out,
	output logic      [2:0]  mod_range_sel,
	output logic      [10:0] mod_full_scale_ua,
	input  wire logic        analog_por_in,
	output logic             analog_por_flag
);

	typedef struct packed {
		tlmc_seq_e   st;
		logic [2:0]  ch;
		logic [2:0]  range;
		logic [7:0]  src_cfg;
		logic [7:0]  mode;
		logic [7:0]  sup_cfg;
		logic [7:0]  idx;
		logic [7:0]  val;
		logic [15:0] res_a;
		logic [15:0] res_b;
		logic [15:0] res_t;
		logic [15:0] res;
		logic [2:0]  res_id;
		logic        res_vld;
		logic [7:0]  rdata;
		logic [1:0]  por_sync;
		logic [10:0] fs;
	} tlmc_state_s;

	localparam tlmc_state_s S_RST = '{
		st:       SEQ_START,
		ch:       CH_TEMP,
		range:    RST_RANGE,
		src_cfg:  RST_SRC_CFG,
		mode:     RST_MODE,
		sup_cfg:  RST_SUPPLY,
		idx:      RST_INDEX,
		val:      RST_VALUE,
		res_a:    16'h0000,
		res_b:    16'h0000,
		res_t:    16'h0000,
		res:      16'h0000,
		res_id:   CH_TEMP,
		res_vld:  1'b0,
		rdata:    8'h00,
		por_sync: 2'h0,
		fs:       FS_UA_0 // full scale of the reset range code
	};

	tlmc_state_s s_ff;
	tlmc_state_s nxt_s;
	logic [7:0]  lut_mem [0:127];
	logic        avg_done;
	logic [15:0] avg_result;
	logic        smp_valid;
	logic        ext_sel;
	logic        table_en;
	logic        auto_en;
	logic        sel_upd;
	logic [15:0] sel_temp;
	logic [15:0] stored;
	logic [7:0]  new_idx;

	// ************************************************
	// helper functions
	// ************************************************
	// channel membership in the sequence
	function automatic logic chan_on(input logic [2:0] c,
			input logic [7:0] cfg);
		logic on;
		on = 1'b1;
		if (c == CH_SUPPLY)
			on = cfg[BIT_SUPPLY_EN];
		else if (c == CH_AUX_A)
			on = cfg[BIT_AUX_A_EN];
		else if (c == CH_AUX_B)
			on = cfg[BIT_AUX_B_EN];
		return on;
	endfunction

	// next enabled channel in fixed order
	function automatic logic [2:0] next_chan(input logic [2:0] c,
			input logic [7:0] cfg);
		logic [2:0] n;
		logic       hit;
		n = c;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			n = (n == CH_AUX_B) ? CH_TEMP : n + 3'h1;
			if (!hit && chan_on(n, cfg))
				hit = 1'b1;
			else if (!hit)
				n = n;
		end
		n = c;
		hit = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (!hit) begin
				n = (n == CH_AUX_B) ? CH_TEMP : n + 3'h1;
				hit = chan_on(n, cfg);
			end
		end
		return n;
	endfunction

	// temperature word to table address
	function automatic logic [7:0] temp_addr(input logic [15:0] t);
		logic [9:0] d;
		logic [6:0] i;
		d = {{2{t[15]}}, t[15:8]} + LUT_LOW_DEG;
		if (d[9])
			i = 7'h00;
		else if (d > LUT_SPAN_DEG)
			i = LUT_LAST_IDX;
		else
			i = d[7:1];
		return LUT_BASE + {1'b0, i};
	endfunction

	// clamp of the internal temperature word
	function automatic logic [15:0] temp_clamp(input logic [15:0] t,
			input logic ext);
		logic signed [15:0] v;
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		v  = t;
		lo = ext ? TEMP_MIN_EXT : TEMP_MIN_INT;
		hi = ext ? TEMP_MAX_EXT : TEMP_MAX_INT;
		if (v < lo)
			v = lo;
		else if (v > hi)
			v = hi;
		return v;
	endfunction

	// full-scale sink current per range code
	function automatic logic [10:0] full_scale(input logic [2:0] r);
		logic [10:0] f;
		unique case (r)
			3'h0: f = FS_UA_0;
			3'h1: f = FS_UA_1;
			3'h2: f = FS_UA_2;
			3'h3: f = FS_UA_3;
			default: f = FS_UA_4;
		endcase
		return f;
	endfunction

	// ************************************************
	// averaging of conversions
	// ************************************************
	assign smp_valid = (s_ff.st == SEQ_WAIT) && adc_done;

	tlmc_avg u_avg (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.smp_valid  (smp_valid),
		.smp_data   (adc_data),
		.smp_temp   (s_ff.ch == CH_TEMP),
		.avg_done   (avg_done),
		.avg_result (avg_result)
	);

	// ************************************************
	// mode decode and selected temperature
	// ************************************************
	assign ext_sel  = s_ff.src_cfg[BIT_EXT_TEMP];
	assign table_en = s_ff.mode[BIT_TABLE_EN];
	assign auto_en  = s_ff.mode[BIT_AUTO_EN];
	// stored word: low bits masked, temperature clamped
	assign stored   = (s_ff.ch == CH_TEMP)
		? temp_clamp(avg_result & RES_MASK, ext_sel)
		: (avg_result & RES_MASK);
	// only internal or aux B may index the table
	assign sel_upd  = (s_ff.st == SEQ_AVG) && avg_done
		&& (ext_sel ? (s_ff.ch == CH_AUX_B)
		: (s_ff.ch == CH_TEMP));
	assign sel_temp = stored;
	assign new_idx  = temp_addr(sel_temp);

	// ************************************************
	// sequencer, registers and pointer control
	// ************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.res_vld = 1'b0;
		nxt_s.por_sync = {s_ff.por_sync[0], analog_por_in};
		unique case (s_ff.st)
			SEQ_START: nxt_s.st = SEQ_WAIT;
			SEQ_WAIT:
				if (adc_done)
					nxt_s.st = SEQ_AVG;
			SEQ_AVG: begin
				nxt_s.st = SEQ_START;
				if (avg_done) begin
					nxt_s.res     = stored;
					nxt_s.res_id  = s_ff.ch;
					nxt_s.res_vld = 1'b1;
					nxt_s.ch = next_chan(s_ff.ch,
						s_ff.src_cfg);
					if (s_ff.ch == CH_TEMP)
						nxt_s.res_t = stored;
					if (s_ff.ch == CH_AUX_A)
						nxt_s.res_a = stored;
					if (s_ff.ch == CH_AUX_B)
						nxt_s.res_b = stored;
				end
			end
			default: nxt_s.st = SEQ_START; // illegal code recovers
		endcase

		// host writes to the configuration page
		if (reg_wr && !reg_lut_sel) begin
			unique case (reg_addr)
				OFS_RANGE:   nxt_s.range = reg_wdata[2:0];
				OFS_SRC_CFG: nxt_s.src_cfg = reg_wdata;
				OFS_MODE:    nxt_s.mode = reg_wdata;
				OFS_SUPPLY:  nxt_s.sup_cfg = reg_wdata;
				OFS_INDEX:
					if (!auto_en)
						nxt_s.idx = reg_wdata;
				OFS_VALUE:
					if (!table_en)
						nxt_s.val = reg_wdata;
				default: nxt_s.rdata = nxt_s.rdata;
			endcase
		end

		// pointer follows temperature while auto is on
		if (sel_upd && auto_en) begin
			nxt_s.idx = new_idx;
			if (table_en)
				nxt_s.val = lut_mem[new_idx[6:0]];
		end else if (table_en && !auto_en) begin
			nxt_s.val = lut_mem[s_ff.idx[6:0]];
		end
		// full scale follows the range register
		nxt_s.fs = full_scale(nxt_s.range);

		// registered read data
		if (reg_rd) begin
			if (reg_lut_sel)
				nxt_s.rdata = lut_mem[reg_addr[6:0]];
			else begin
				unique case (reg_addr)
					OFS_AUX_A_HI: nxt_s.rdata = s_ff.res_a[15:8];
					OFS_AUX_A_LO: nxt_s.rdata = s_ff.res_a[7:0];
					OFS_AUX_B_HI: nxt_s.rdata = s_ff.res_b[15:8];
					OFS_AUX_B_LO: nxt_s.rdata = s_ff.res_b[7:0];
					OFS_RANGE:   nxt_s.rdata = {5'h00, s_ff.range};
					OFS_SRC_CFG: nxt_s.rdata = s_ff.src_cfg;
					OFS_INDEX:   nxt_s.rdata = s_ff.idx;
					OFS_VALUE:   nxt_s.rdata = s_ff.val;
					OFS_MODE:    nxt_s.rdata = s_ff.mode;
					OFS_SUPPLY:  nxt_s.rdata = s_ff.sup_cfg;
					default:     nxt_s.rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			s_ff <= S_RST;
		else
			s_ff <= nxt_s;
	end

	// ************************************************
	// lookup table storage
	// ************************************************
	always_ff @(posedge ref_clk) begin
		if (reg_wr && reg_lut_sel)
			lut_mem[reg_addr[6:0]] <= reg_wdata;
	end

	// ************************************************
	// outputs
	// ************************************************
	// host, sequencer and result outputs
	assign reg_rdata         = s_ff.rdata;
	assign adc_start         = (s_ff.st == SEQ_START);
	assign adc_chan          = s_ff.ch;
	assign adc_supply_sel    = s_ff.sup_cfg[BIT_SUPPLY_SEL];
	assign chan_result_vld   = s_ff.res_vld;
	assign chan_result_id    = s_ff.res_id;
	assign chan_result       = s_ff.res;
	assign int_temp_upd      = s_ff.res_vld
		&& (s_ff.res_id == CH_TEMP);
	assign int_temp_result   = s_ff.res_t;
	assign aux_b_upd         = s_ff.res_vld
		&& (s_ff.res_id == CH_AUX_B);
	// modulation outputs and power-on flag
	assign mod_current_out   = s_ff.val;
	assign mod_range_sel     = s_ff.range;
	assign mod_full_scale_ua = s_ff.fs;
	assign analog_por_flag   = s_ff.por_sync[1];

endmodule // tlmc_top

// File: rtl/tlmc_top_note.sv
// intentionally empty

// File: verif/tlmc_monitor.sv
module tlmc_monitor import tlmc_pkg::*; (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        adc_start,
	input wire logic [2:0]  adc_chan,
	input wire logic        adc_done,
	input wire logic        chan_result_vld,
	input wire logic [2:0]  chan_result_id,
	input wire logic [15:0] chan_result,
	input wire logic        int_temp_upd,
	input wire logic [15:0] int_temp_result,
	input wire logic        aux_b_upd,
	input wire logic [2:0]  mod_range_sel,
	input wire logic [10:0] mod_full_scale_ua,
	input wire logic        analog_por_in,
	input wire logic        analog_por_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ********************
	// helper counters
	// ********************
	logic [4:0] cnt_ff;
	logic [1:0] age_ff;
	// conversions since last result, edges since reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 5'h00;
			age_ff <= 2'h0;
		end else begin
			if (chan_result_vld)
				cnt_ff <= 5'h00;
			else if (adc_done)
				cnt_ff <= cnt_ff + 5'h01;
			if (age_ff != 2'h3)
				age_ff <= age_ff + 2'h1;
		end
	end
	// ********************
	// properties
	// ********************
	sequence s_start;
		adc_start;
	endsequence
	sequence s_last_done;
		adc_done && adc_chan == 3'h0 && cnt_ff == 5'h0F;
	endsequence
	property p_fs;
		mod_full_scale_ua == (11'h04B << ((mod_range_sel > 3'h4) ? 3'h4
			: mod_range_sel));
	endproperty
	property p_start;
		s_start |-> adc_chan != 3'h7 ##1 !adc_start;
	endproperty
	property p_avg_n;
		chan_result_vld |-> cnt_ff == ((chan_result_id == 3'h0) ? 5'h10
			: 5'h08);
	endproperty
	property p_last;
		s_last_done |-> ##2 chan_result_vld && chan_result_id == 3'h0;
	endproperty
	property p_lsb;
		chan_result_vld |-> chan_result[2:0] == 3'h0;
	endproperty
	property p_temp_upd;
		int_temp_upd == (chan_result_vld && chan_result_id == 3'h0) &&
			(!int_temp_upd || int_temp_result == chan_result);
	endproperty
	property p_aux_b;
		aux_b_upd == (chan_result_vld && chan_result_id == 3'h6);
	endproperty
	property p_por;
		age_ff == 2'h3 |-> analog_por_flag == $past(analog_por_in, 2);
	endproperty
	a_fs: assert property (p_fs) else $error("full scale wrong");
	a_start: assert property (p_start) else $error("bad start");
	a_avg_n: assert property (p_avg_n) else $error("bad count");
	a_last: assert property (p_last) else $error("late temp");
	a_lsb: assert property (p_lsb) else $error("low bits set");
	a_temp_upd: assert property (p_temp_upd) else $error("tmp upd");
	a_aux_b: assert property (p_aux_b) else $error("aux b upd");
	a_por: assert property (p_por) else $error("por flag");
endmodule // tlmc_monitor

bind tlmc_top tlmc_monitor u_mon (.ref_clk, .reset, .adc_start, .adc_chan,
	.adc_done, .chan_result_vld, .chan_result_id, .chan_result,
	.int_temp_upd, .int_temp_result, .aux_b_upd, .mod_range_sel,
	.mod_full_scale_ua, .analog_por_in, .analog_por_flag);

// File: verif/tlmc_adc_model.sv
module tlmc_adc_model (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        adc_start,
	input  wire logic [2:0]  adc_chan,
	input  wire logic        adc_supply_sel,
	input  logic      [15:0] base [7],
	input  wire logic [1:0]  lat,
	output logic             adc_done,
	output logic      [15:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ch;
	logic [2:0] last_ch;
	logic [3:0] k;
	// one conversion per start, sample rises by 8 per repeat
	initial begin
		adc_done = 1'b0;
		adc_data = 16'h0000;
		last_ch = 3'h7;
		k = 4'h0;
		forever begin
			@(posedge ref_clk);
			if (adc_start === 1'b1 && reset === 1'b0) begin
				ch = adc_chan;
				k = (ch == last_ch) ? k + 4'h1 : 4'h0;
				last_ch = ch;
				repeat (lat) @(posedge ref_clk);
				#1;
				adc_done = 1'b1;
				adc_data = base[ch] + {9'h000, k, 3'h0} +
					((ch == 3'h1 && adc_supply_sel) ? 16'h1000 : 16'h0000);
				@(posedge ref_clk);
				#1;
				adc_done = 1'b0;
				adc_data = ~adc_data;
			end
		end
	end
endmodule // tlmc_adc_model

// File: verif/tlmc_tb_top.sv
module tlmc_tb_top import tlmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ********************
	// signals
	// ********************
	logic        ref_clk, reset, reg_wr, reg_rd, reg_lut_sel;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, mod_current_out, v;
	logic        adc_start, adc_supply_sel, adc_done, chan_result_vld;
	logic [2:0]  adc_chan, chan_result_id, mod_range_sel;
	logic [15:0] adc_data, chan_result, int_temp_result;
	logic        int_temp_upd, aux_b_upd, analog_por_in, analog_por_flag;
	logic [10:0] mod_full_scale_ua;
	logic [15:0] base [7];
	logic [7:0]  tbl [72];
	logic [7:0]  exp_q [$];
	logic [7:0]  cfg;
	logic [1:0]  lat;
	logic        sup, chk_on;
	int          err_count, tests_run, last_id;
	int          temps [5] = '{-50, -40, 25, 102, 110};
	int          idx [3] = '{0, 71, 33};
	tlmc_top dut (.ref_clk, .reset, .reg_wr, .reg_rd, .reg_lut_sel,
		.reg_addr, .reg_wdata, .reg_rdata, .adc_start, .adc_chan,
		.adc_supply_sel, .adc_done, .adc_data, .chan_result_vld,
		.chan_result_id, .chan_result, .int_temp_upd, .int_temp_result,
		.aux_b_upd, .mod_current_out, .mod_range_sel, .mod_full_scale_ua,
		.analog_por_in, .analog_por_flag);
	tlmc_adc_model u_adc (.ref_clk, .reset, .adc_start, .adc_chan,
		.adc_supply_sel, .base, .lat, .adc_done, .adc_data);
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ********************
	// tasks and models
	// ********************
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] e);
		tests_run++;
		if (got !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, e);
		end
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
		cmp16({8'h00, got}, {8'h00, e});
	endtask
	task automatic wr(input logic [7:0] a, d, input logic lut = 1'b0);
		reg_wr = 1'b1;
		reg_lut_sel = lut;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_rd = 1'b1;
		reg_lut_sel = 1'b0;
		reg_addr = a;
		tick();
		reg_rd = 1'b0;
		tick();
	endtask
	task automatic wait_temp(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge ref_clk);
			while (int_temp_upd !== 1'b1 && c < 5000) begin
				@(posedge ref_clk);
				c++;
			end
		end
		if (c >= 5000) begin
			err_count++;
			$display("unexpected stall at %0t: got %h exp %h", $time, 0, 1);
		end
		#1;
	endtask
	// let changes flush, then check exactly one full frame
	task automatic settle;
		chk_on = 1'b0;
		lat = 2'($urandom_range(2));
		wait_temp(2);
		chk_on = 1'b1;
		wait_temp(1);
		chk_on = 1'b0;
	endtask
	function automatic int idx_of(input int d);
		return (d < -40) ? 0 : (d > 102) ? 71 : (d + 40) / 2;
	endfunction
	function automatic logic [2:0] nxt_ch(input logic [2:0] c);
		logic [2:0] n;
		n = c;
		do n = (n == 3'h6) ? 3'h0 : n + 3'h1;
		while ((n == 3'h1 && !cfg[2]) || (n == 3'h5 && !cfg[0]) ||
			(n == 3'h6 && !cfg[1]));
		return n;
	endfunction
	function automatic logic [15:0] exp_res(input logic [2:0] c);
		logic signed [15:0] r;
		r = base[c] + ((c == 3'h0) ? 16'd60 : 16'd28);
		if (c == 3'h1 && sup)
			r = r + 16'h1000;
		r = r & 16'shFFF8;
		if (c == 3'h0 && cfg[3] && r > 16'sh67F0)
			r = 16'sh67F0;
		return r;
	endfunction
	// read data watcher
	initial forever begin
		@(posedge ref_clk);
		if (reg_rd === 1'b1) begin
			#2;
			cmp8(reg_rdata, exp_q.pop_front());
		end
	end
	// channel result watcher
	always @(posedge ref_clk) begin
		if (chan_result_vld === 1'b1 && chk_on) begin
			if (last_id >= 0)
				cmp16({13'h0, chan_result_id}, {13'h0, nxt_ch(3'(last_id))});
			cmp16(chan_result, exp_res(chan_result_id));
		end
		if (chan_result_vld === 1'b1)
			last_id = chk_on ? int'(chan_result_id) : -1;
	end
	// ********************
	// main sequence
	// ********************
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#3000000;
		err_count++;
		$display("unexpected timeout at %0t: got %h exp %h", $time, 0, 1);
		summarize();
	end
	initial begin
		{reg_wr, reg_rd, reg_lut_sel, reg_addr, reg_wdata} = '0;
		{analog_por_in, sup, chk_on, lat, err_count, tests_run} = '0;
		reset = 1'b1;
		last_id = -1;
		cfg = 8'h07;
		base = '{16'h0, 16'h2000, 16'h3000, 16'h4000, 16'h5000, 16'h6000,
			16'h0A00};
		void'($urandom(95));
		repeat (8) @(posedge ref_clk);
		#1 reset = 1'b0;
		rd(OFS_MODE, 8'h03);
		rd(OFS_SRC_CFG, 8'h07);
		rd(OFS_INDEX, 8'h80);
		rd(8'h10, 8'h00);
		analog_por_in = 1'b1;
		repeat (3) tick();
		cmp8({7'h0, analog_por_flag}, 8'h01);
		$display("test reset done");
		for (int r = 0; r < 5; r++) begin
			wr(OFS_RANGE, {5'h1F, 3'(r)});
			rd(OFS_RANGE, 8'(r));
			cmp8({5'h00, mod_range_sel}, 8'(r));
			cmp16({5'h00, mod_full_scale_ua}, 16'(75 << r));
		end
		$display("test range done");
		sup = 1'b1;
		wr(OFS_SUPPLY, 8'h01);
		wr(OFS_AUX_A_HI, 8'hFF);
		for (int n = 0; n < 72; n++) begin
			tbl[n] = 8'($urandom);
			wr(8'(128 + n), tbl[n], 1'b1);
		end
		foreach (temps[i]) begin
			base[0] = 16'(temps[i] * 256);
			settle();
			rd(OFS_INDEX, 8'(128 + idx_of(temps[i])));
			cmp8(mod_current_out, tbl[idx_of(temps[i])]);
		end
		wr(OFS_INDEX, 8'h85);
		rd(OFS_INDEX, 8'hC7);
		$display("test auto done");
		wr(OFS_MODE, 8'h01);
		v = 8'($urandom);
		wr(OFS_VALUE, v);
		base[0] = 16'h1900;
		settle();
		rd(OFS_INDEX, 8'hA0);
		cmp8(mod_current_out, v);
		wr(OFS_MODE, 8'h00);
		wr(OFS_VALUE, 8'hFF);
		base[0] = 16'hCE00;
		settle();
		rd(OFS_INDEX, 8'hA0);
		cmp8(mod_current_out, 8'hFF);
		wr(OFS_MODE, 8'h02);
		foreach (idx[i]) begin
			wr(OFS_INDEX, 8'(128 + idx[i]));
			wr(OFS_VALUE, ~tbl[idx[i]]);
			cmp8(mod_current_out, tbl[idx[i]]);
		end
		$display("test manual done");
		foreach (idx[i]) begin
			cfg = 8'(idx[i]) & 8'h07;
			sup = ~cfg[0];
			wr(OFS_SRC_CFG, cfg);
			wr(OFS_SUPPLY, {7'h00, sup});
			rd(OFS_SUPPLY, {7'h00, sup});
			settle();
		end
		$display("test disable done");
		wr(OFS_MODE, 8'h03);
		cfg = 8'h0F;
		wr(OFS_SRC_CFG, cfg);
		base[0] = 16'h6E00;
		settle();
		rd(OFS_INDEX, 8'h99);
		cmp8(mod_current_out, tbl[25]);
		cmp16(int_temp_result, 16'h67F0);
		rd(OFS_AUX_B_HI, 8'h0A);
		rd(OFS_AUX_B_LO, 8'h18);
		rd(OFS_AUX_A_HI, 8'h60);
		$display("test external done");
		summarize();
	end
endmodule // tlmc_tb_top
